// [src/oag_pkg.sv]
// Purpose: Shared constants and types for the operand address generator
// Assumes: 16-bit instruction words, 32-bit addresses
// Notes: Mode and size codes are used by the generator and its bench
package oag_pkg;

    // ********************************************************
    // Widths and field positions
    // ********************************************************
    localparam int ADDR_W = 32;
    localparam int INSN_W = 16;
    localparam int DST_HI = 11;
    localparam int DST_LO = 8;
    localparam int SRC_HI = 7;
    localparam int SRC_LO = 4;
    localparam int D4_HI = 3;
    localparam int D8_HI = 7;
    localparam int D12_HI = 11;
    localparam int OP_HI = 15;
    localparam int OP_LO = 12;
    localparam logic [31:0] LONG_MASK = 32'hffff_fffc;
    localparam logic [31:0] ADDR_ZERO = 32'h0000_0000;
    localparam logic [3:0] SEL_ZERO = 4'h0;

    // ********************************************************
    // Operand sizes
    // ********************************************************
    typedef enum logic [1:0] {
        OAG_SZ_BYTE = 2'h0,
        OAG_SZ_WORD = 2'h1,
        OAG_SZ_LONG = 2'h2
    } oag_size_t;

    // ********************************************************
    // Addressing forms selected by the opcode decoder
    // ********************************************************
    typedef enum logic [3:0] {
        OAG_M_NONE = 4'h0,     // No memory operand
        OAG_M_DISP4 = 4'h1,    // Register plus scaled 4-bit disp
        OAG_M_IDX = 4'h2,      // Register plus index register zero
        OAG_M_BASE8 = 4'h3,    // Global base plus scaled 8-bit disp
        OAG_M_BASEIDX = 4'h4,  // Global base plus index register zero
        OAG_M_PCDATA = 4'h5,   // PC-relative data, 8-bit disp
        OAG_M_BR8 = 4'h6,      // Branch, signed 8-bit disp
        OAG_M_BR12 = 4'h7,     // Branch, signed 12-bit disp
        OAG_M_STIDX = 4'h8,    // Store to dest register plus index zero
        OAG_M_MACW = 4'h9,     // Multiply-accumulate word, post-increment
        OAG_M_LDCTL = 4'ha     // Load control reg, source post-increment
    } oag_mode_t;

    // Where the operand fields are interpreted to go
    typedef enum logic [1:0] {
        OAG_F_GPR = 2'h0,
        OAG_F_CTRL = 2'h1,
        OAG_F_MEM = 2'h2,
        OAG_F_ACC = 2'h3
    } oag_field_t;

endpackage

// [src/oag_operand_address_generator.sv]
// Purpose: Effective-address generation and operand-field reading
// Assumes: Opcode decode supplies mode and size; register values supplied
// Notes: One-cycle registered result after each valid request
//
// Overview of operation
// - Register plus zero-extended scaled 4-bit disp
// - Register plus index register zero, unscaled
// - Global base plus zero-extended scaled 8-bit disp
// - Global base plus index register zero
// - PC plus zero-extended 8-bit disp, x2/x4
// - Longword PC-relative clears low two PC bits
// - Branch: sign-extended 8-bit disp doubled
// - Branch: sign-extended 12-bit disp doubled
// - Split instruction into opcode, selectors, displacement
// - Opcode decides meaning of operand fields
// - Store to destination register plus index zero
// - Multiply-accumulate reads both post-incremented
// - Control load from source then increment
// - Misaligned word or longword raises address error
`timescale 1ns/1ps
module oag_operand_address_generator #(
    parameter int ADDR_WIDTH = 32
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic [15:0] instruction,
    input wire logic [3:0] mode,
    input wire logic [1:0] size,
    input wire logic [31:0] destination_general_register,
    input wire logic [31:0] source_general_register,
    input wire logic [31:0] index_register_zero,
    input wire logic [31:0] global_base_register,
    input wire logic [31:0] program_counter,
    output logic ea_valid,
    output logic [31:0] effective_address,
    output logic address_error,
    output logic [3:0] dest_select,
    output logic [3:0] src_select,
    output logic [3:0] opcode_field,
    output logic [1:0] src_kind,
    output logic [1:0] dst_kind,
    output logic [31:0] second_address,
    output logic src_post_inc,
    output logic dst_post_inc,
    output logic acc_write
);

    // Elaboration check: arithmetic is fixed at the package width
    if (ADDR_WIDTH != oag_pkg::ADDR_W) begin : g_bad_width
        $error("ADDR_WIDTH must equal 32");
    end

    // ********************************************************
    // Helper functions
    // ********************************************************
    // Scale a zero-extended displacement by operand size
    function automatic logic [31:0] scale_disp(input logic [31:0] d, input logic [1:0] sz);
        case (sz)
            oag_pkg::OAG_SZ_WORD: scale_disp = {d[30:0], 1'b0};
            oag_pkg::OAG_SZ_LONG: scale_disp = {d[29:0], 2'b00};
            default: scale_disp = d;
        endcase
    endfunction

    // Operand alignment test for word and longword sizes
    function automatic logic misaligned(input logic [31:0] a, input logic [1:0] sz);
        case (sz)
            oag_pkg::OAG_SZ_WORD: misaligned = a[0];
            oag_pkg::OAG_SZ_LONG: misaligned = a[1] | a[0];
            default: misaligned = 1'b0;
        endcase
    endfunction

    // 32-bit sum, carry out discarded
    function automatic logic [31:0] add32(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b};
        add32 = s[31:0];
    endfunction

    // ********************************************************
    // Field extraction
    // ********************************************************
    logic [3:0] f_dst; // Destination selector
    logic [3:0] f_src; // Source selector
    logic [3:0] f_op; // Top opcode nibble
    logic [31:0] d4_z; // Zero-extended 4-bit disp
    logic [31:0] d8_z; // Zero-extended 8-bit disp
    logic [31:0] d8_s; // Sign-extended 8-bit disp
    logic [31:0] d12_s; // Sign-extended 12-bit disp
    assign f_dst = instruction[oag_pkg::DST_HI:oag_pkg::DST_LO];
    assign f_src = instruction[oag_pkg::SRC_HI:oag_pkg::SRC_LO];
    assign f_op = instruction[oag_pkg::OP_HI:oag_pkg::OP_LO];
    assign d4_z = {28'h0000000, instruction[oag_pkg::D4_HI:0]};
    assign d8_z = {24'h000000, instruction[oag_pkg::D8_HI:0]};
    assign d8_s = {{24{instruction[oag_pkg::D8_HI]}}, instruction[oag_pkg::D8_HI:0]};
    assign d12_s = {{20{instruction[oag_pkg::D12_HI]}}, instruction[oag_pkg::D12_HI:0]};

    // ********************************************************
    // Next-state computation
    // ********************************************************
    logic next_ea_valid;
    logic [31:0] next_effective_address;
    logic next_address_error;
    logic [3:0] next_dest_select;
    logic [3:0] next_src_select;
    logic [3:0] next_opcode_field;
    logic [1:0] next_src_kind;
    logic [1:0] next_dst_kind;
    logic [31:0] next_second_address;
    logic next_src_post_inc;
    logic next_dst_post_inc;
    logic next_acc_write;
    logic chk_align; // Memory operand present, alignment applies

    // Address forming and field interpretation from the mode
    always_comb begin
        next_ea_valid = req_valid;
        next_effective_address = oag_pkg::ADDR_ZERO;
        next_second_address = oag_pkg::ADDR_ZERO;
        next_dest_select = f_dst;
        next_src_select = f_src;
        next_opcode_field = f_op;
        next_src_kind = oag_pkg::OAG_F_GPR;
        next_dst_kind = oag_pkg::OAG_F_GPR;
        next_src_post_inc = 1'b0;
        next_dst_post_inc = 1'b0;
        next_acc_write = 1'b0;
        chk_align = 1'b1;
        case (mode)
            oag_pkg::OAG_M_DISP4: begin
                // Base register always comes from the source general register
                next_effective_address = add32(source_general_register, scale_disp(d4_z, size));
                next_src_kind = oag_pkg::OAG_F_MEM;
            end
            oag_pkg::OAG_M_IDX: begin
                next_effective_address = add32(source_general_register, index_register_zero);
                next_src_kind = oag_pkg::OAG_F_MEM;
            end
            oag_pkg::OAG_M_BASE8: begin
                next_effective_address = add32(global_base_register, scale_disp(d8_z, size));
                next_src_select = oag_pkg::SEL_ZERO;
                next_src_kind = oag_pkg::OAG_F_MEM;
            end
            oag_pkg::OAG_M_BASEIDX: begin
                next_effective_address = add32(global_base_register, index_register_zero);
                next_src_select = oag_pkg::SEL_ZERO;
                next_src_kind = oag_pkg::OAG_F_MEM;
            end
            oag_pkg::OAG_M_PCDATA: begin
                // Longword reads start from a longword-aligned PC
                if (size == oag_pkg::OAG_SZ_LONG) begin
                    next_effective_address = add32(program_counter & oag_pkg::LONG_MASK,
                                                   scale_disp(d8_z, size));
                end else begin
                    next_effective_address = add32(program_counter,
                                                   scale_disp(d8_z, oag_pkg::OAG_SZ_WORD));
                end
                next_src_kind = oag_pkg::OAG_F_MEM;
            end
            oag_pkg::OAG_M_BR8: begin
                next_effective_address = add32(program_counter, {d8_s[30:0], 1'b0});
                chk_align = 1'b0;
            end
            oag_pkg::OAG_M_BR12: begin
                next_effective_address = add32(program_counter, {d12_s[30:0], 1'b0});
                chk_align = 1'b0;
            end
            oag_pkg::OAG_M_STIDX: begin
                next_effective_address = add32(destination_general_register, index_register_zero);
                next_dst_kind = oag_pkg::OAG_F_MEM;
            end
            oag_pkg::OAG_M_MACW: begin
                // Both operands via post-increment, result to accumulator pair
                next_effective_address = source_general_register;
                next_second_address = destination_general_register;
                next_src_kind = oag_pkg::OAG_F_MEM;
                next_dst_kind = oag_pkg::OAG_F_ACC;
                next_src_post_inc = 1'b1;
                next_dst_post_inc = 1'b1;
                next_acc_write = 1'b1;
            end
            oag_pkg::OAG_M_LDCTL: begin
                next_effective_address = source_general_register;
                next_src_kind = oag_pkg::OAG_F_MEM;
                next_dst_kind = oag_pkg::OAG_F_CTRL;
                next_src_post_inc = 1'b1;
            end
            default: begin
                chk_align = 1'b0;
            end
        endcase
        next_address_error = req_valid & chk_align &
                             (misaligned(next_effective_address, size) |
                              misaligned(next_second_address, size));
    end

    // ********************************************************
    // Output registers
    // ********************************************************
    // Register every result so outputs come from flip-flops
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ea_valid <= 1'b0;
            effective_address <= oag_pkg::ADDR_ZERO;
            address_error <= 1'b0;
            dest_select <= oag_pkg::SEL_ZERO;
            src_select <= oag_pkg::SEL_ZERO;
            opcode_field <= oag_pkg::SEL_ZERO;
            src_kind <= 2'h0;
            dst_kind <= 2'h0;
            second_address <= oag_pkg::ADDR_ZERO;
            src_post_inc <= 1'b0;
            dst_post_inc <= 1'b0;
            acc_write <= 1'b0;
        end else begin
            ea_valid <= next_ea_valid;
            effective_address <= next_effective_address;
            address_error <= next_address_error;
            dest_select <= next_dest_select;
            src_select <= next_src_select;
            opcode_field <= next_opcode_field;
            src_kind <= next_src_kind;
            dst_kind <= next_dst_kind;
            second_address <= next_second_address;
            src_post_inc <= next_src_post_inc;
            dst_post_inc <= next_dst_post_inc;
            acc_write <= next_acc_write;
        end
    end

endmodule

// [tb/oag_checker.sv]
// Purpose: Concurrent checks on the operand address generator ports
// Assumes: Results appear one core_clk edge after the request edge
// Notes: Inputs are held one cycle in helper flops to form expectations
`timescale 1ns/1ps
module oag_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic [15:0] instruction,
    input wire logic [3:0] mode,
    input wire logic [1:0] size,
    input wire logic [31:0] destination_general_register,
    input wire logic [31:0] source_general_register,
    input wire logic [31:0] index_register_zero,
    input wire logic [31:0] global_base_register,
    input wire logic [31:0] program_counter,
    input wire logic ea_valid,
    input wire logic [31:0] effective_address,
    input wire logic address_error,
    input wire logic [3:0] dest_select,
    input wire logic [3:0] src_select,
    input wire logic [3:0] opcode_field
);
    // ****************************************
    // Request inputs held for one cycle
    // ****************************************
    logic [31:0] src_q, dst_q, idx_q, base_q, pc_q;
    logic [15:0] ins_q;
    // Plain copies, compared against the registered result
    always_ff @(posedge core_clk) begin
        src_q <= source_general_register;
        dst_q <= destination_general_register;
        idx_q <= index_register_zero;
        base_q <= global_base_register;
        pc_q <= program_counter;
        ins_q <= instruction;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ****************************************
    // Assertions
    // ****************************************
    a_valid_pulse: assert property (req_valid |=> ea_valid ##1 (ea_valid == $past(req_valid)))
        else $error("result strobe does not follow request");
    a_disp4_word: assert property (req_valid && mode == oag_pkg::OAG_M_DISP4 && size == 2'h1
        |=> effective_address == src_q + {27'h0, ins_q[3:0], 1'h0}) else $error("disp4 word address wrong");
    a_index_sum: assert property (req_valid && mode == oag_pkg::OAG_M_IDX
        |=> effective_address == src_q + idx_q && src_select == ins_q[7:4]) else $error("indexed address wrong");
    a_base_long: assert property (req_valid && mode == oag_pkg::OAG_M_BASE8 && size == 2'h2
        |=> effective_address == base_q + {22'h0, ins_q[7:0], 2'h0}) else $error("base disp address wrong");
    a_base_index: assert property (req_valid && mode == oag_pkg::OAG_M_BASEIDX
        |=> effective_address == base_q + idx_q) else $error("base index address wrong");
    a_pc_long: assert property (req_valid && mode == oag_pkg::OAG_M_PCDATA && size == 2'h2
        |=> effective_address == (pc_q & oag_pkg::LONG_MASK) + {22'h0, ins_q[7:0], 2'h0})
        else $error("pc long address wrong");
    a_branch_short: assert property (req_valid && mode == oag_pkg::OAG_M_BR8
        |=> effective_address == pc_q + {{23{ins_q[7]}}, ins_q[7:0], 1'h0}) else $error("short branch wrong");
    a_branch_long: assert property (req_valid && mode == oag_pkg::OAG_M_BR12
        |=> effective_address == pc_q + {{19{ins_q[11]}}, ins_q[11:0], 1'h0}) else $error("long branch wrong");
    a_store_index: assert property (req_valid && mode == oag_pkg::OAG_M_STIDX
        |=> effective_address == dst_q + idx_q) else $error("store index address wrong");
    a_field_select: assert property (req_valid
        |=> dest_select == ins_q[11:8] && opcode_field == ins_q[15:12]) else $error("field selectors wrong");
    a_word_misalign: assert property (req_valid && mode == oag_pkg::OAG_M_IDX && size == 2'h1
        |=> address_error == effective_address[0]) else $error("word alignment flag wrong");
endmodule
bind oag_operand_address_generator oag_checker chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .instruction(instruction), .mode(mode), .size(size),
    .destination_general_register(destination_general_register),
    .source_general_register(source_general_register), .index_register_zero(index_register_zero),
    .global_base_register(global_base_register), .program_counter(program_counter), .ea_valid(ea_valid),
    .effective_address(effective_address), .address_error(address_error), .dest_select(dest_select),
    .src_select(src_select), .opcode_field(opcode_field));

// [tb/oag_operand_address_generator_tb.sv]
// Purpose: Directed bench for the operand address generator
// Assumes: 200 MHz core_clk, inputs driven 1 ns after the rising edge
// Notes: Each request is checked one edge later, then the strobe drops
`timescale 1ns/1ps
module oag_operand_address_generator_tb;
    logic clk = 1'h0, rst = 1'h1, rv = 1'h0, ev, ae, sp, dp, aw;
    logic [15:0] ins = 16'h0;
    logic [3:0] md = 4'h0, ds, ss, of;
    logic [1:0] sz = 2'h0, sk, dk;
    logic [31:0] dr = 32'h0, sr = 32'h0, iz = 32'h0, gb = 32'h0, pc = 32'h0, ea, sa;
    int mismatches = 0;
    int checks = 0;
    // Clock: 5 ns period
    initial begin
        forever #2.5 clk = ~clk;
    end
    oag_operand_address_generator uut (.core_clk(clk), .sys_rst(rst), .req_valid(rv), .instruction(ins),
        .mode(md), .size(sz), .destination_general_register(dr), .source_general_register(sr),
        .index_register_zero(iz), .global_base_register(gb), .program_counter(pc), .ea_valid(ev),
        .effective_address(ea), .address_error(ae), .dest_select(ds), .src_select(ss), .opcode_field(of),
        .src_kind(sk), .dst_kind(dk), .second_address(sa), .src_post_inc(sp), .dst_post_inc(dp),
        .acc_write(aw));
    // ****************************************
    // Shared tasks
    // ****************************************
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One request; returns with its result settled
    task automatic go(input logic [3:0] m, input logic [1:0] s, input logic [15:0] i);
        @(posedge clk);
        #1;
        chk({31'h0, ev}, 32'h0);
        md = m;
        sz = s;
        ins = i;
        rv = 1'h1;
        @(posedge clk);
        #1;
        rv = 1'h0;
        chk({31'h0, ev}, 32'h1);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    // Scaled 4-bit disp with wrap and alignment flag
    task automatic t_disp4;
        logic [31:0] e;
        sr = 32'hffff_fff1;
        for (int k = 0; k < 3; k++) begin
            go(oag_pkg::OAG_M_DISP4, k[1:0], 16'h512f);
            e = sr + (32'hf << k);
            chk(ea, e);
            chk({31'h0, ae}, {31'h0, (k == 1 && e[0]) || (k == 2 && e[1:0] != 2'h0)});
        end
    endtask
    // Indexed forms and field split
    task automatic t_index;
        dr = 32'h8000_0000;
        iz = 32'h8000_0004;
        sr = 32'h0000_0010;
        go(oag_pkg::OAG_M_IDX, 2'h1, 16'h0ab0);
        chk(ea, 32'h8000_0014);
        chk({24'h0, ds, ss}, 32'hab);
        go(oag_pkg::OAG_M_STIDX, 2'h2, 16'h2cd0);
        chk(ea, 32'h0000_0004);
        chk({28'h0, of}, 32'h2);
        chk({28'h0, dk, sk}, {28'h0, oag_pkg::OAG_F_MEM, oag_pkg::OAG_F_GPR});
    endtask
    // Global base forms
    task automatic t_base;
        gb = 32'h0000_1000;
        iz = 32'h0000_0002;
        for (int k = 0; k < 3; k++) begin
            go(oag_pkg::OAG_M_BASE8, k[1:0], 16'hc0ff);
            chk(ea, gb + (32'hff << k));
        end
        go(oag_pkg::OAG_M_BASEIDX, 2'h0, 16'hcc00);
        chk(ea, 32'h0000_1002);
    endtask
    // PC-relative data and branches
    task automatic t_pcrel;
        pc = 32'h0000_2003;
        go(oag_pkg::OAG_M_PCDATA, 2'h1, 16'h9180);
        chk(ea, 32'h0000_2103);
        chk({31'h0, ae}, 32'h1);
        go(oag_pkg::OAG_M_PCDATA, 2'h2, 16'hd380);
        chk(ea, 32'h0000_2200);
        pc = 32'h0000_4000;
        go(oag_pkg::OAG_M_BR8, 2'h0, 16'h8b80);
        chk(ea, 32'h0000_3f00);
        go(oag_pkg::OAG_M_BR12, 2'h0, 16'ha800);
        chk(ea, 32'h0000_3000);
        go(oag_pkg::OAG_M_BR12, 2'h0, 16'ha7ff);
        chk(ea, 32'h0000_4ffe);
    endtask
    // Post-increment forms and operand kinds
    task automatic t_postinc;
        sr = 32'h0000_0100;
        dr = 32'h0000_0200;
        go(oag_pkg::OAG_M_MACW, 2'h1, 16'h045f);
        chk(ea, 32'h0000_0100);
        chk(sa, 32'h0000_0200);
        chk({29'h0, sp, dp, aw}, 32'h7);
        chk({30'h0, dk}, {30'h0, oag_pkg::OAG_F_ACC});
        chk({30'h0, sk}, {30'h0, oag_pkg::OAG_F_MEM});
        go(oag_pkg::OAG_M_LDCTL, 2'h2, 16'h4037);
        chk(ea, 32'h0000_0100);
        chk({29'h0, sp, dp, aw}, 32'h4);
        chk({30'h0, dk}, {30'h0, oag_pkg::OAG_F_CTRL});
        chk(sa, oag_pkg::ADDR_ZERO);
        // No memory operand: address stays zero and no error is raised
        go(oag_pkg::OAG_M_NONE, 2'h2, 16'h0003);
        chk(ea, oag_pkg::ADDR_ZERO);
        chk({31'h0, ae}, 32'h0);
    endtask
    // Summary and verdict
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst = 1'h0;
        t_disp4();
        t_index();
        t_base();
        t_pcrel();
        t_postinc();
        print_verdict();
    end
    // Watchdog
    initial begin
        #5000;
        mismatches++;
        print_verdict();
    end
endmodule
